/* src/rwb_apb_regs.sv */
// apb slave holding the control, status and counter registers
`timescale 1ns/1ps
module rwb_apb_regs
    import rwb_pkg::*;
(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // block side
    output logic                      ctrl_enable,
    input  wire logic [RWB_ST_W-1:0]  status_bits,
    input  wire logic [RWB_CNT_W-1:0] read_count,
    input  wire logic [RWB_CNT_W-1:0] write_count
);

    // address decode for the error answer; the read mux decodes paddr with its own case
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == RWB_CTRL_ADDR) || (a == RWB_STATUS_ADDR) ||
                   (a == RWB_RDCNT_ADDR) || (a == RWB_WRCNT_ADDR);
    endfunction

    rwb_apb_phase_t phase;
    logic [31:0]    next_rdata;
    wire            setup_cyc  = psel & ~penable;
    wire            access_cyc = psel & penable;
    wire            wr_ctrl    = access_cyc & pwrite & (paddr == RWB_CTRL_ADDR);

    // read data picked in the setup cycle, so prdata comes from a flop
    always_comb begin
        next_rdata = RWB_ZERO_WORD;
        case (paddr)
            RWB_CTRL_ADDR:   next_rdata[RWB_CTRL_ENABLE_BIT] = ctrl_enable;
            RWB_STATUS_ADDR: next_rdata[RWB_ST_W-1:0] = status_bits;
            RWB_RDCNT_ADDR:  next_rdata[RWB_CNT_W-1:0] = read_count;
            RWB_WRCNT_ADDR:  next_rdata[RWB_CNT_W-1:0] = write_count;
            default:         next_rdata = RWB_ZERO_WORD;
        endcase
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access_cyc & ~addr_hit(paddr);

    // phase tracker and read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase  <= RWB_APB_IDLE;
            prdata <= RWB_ZERO_WORD;
        end else begin
            phase <= setup_cyc ? RWB_APB_SETUP :
                     (access_cyc ? RWB_APB_ACCESS : RWB_APB_IDLE);
            if (setup_cyc && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // control register, written at the access edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_enable <= RWB_CTRL_ENABLE_RST;
        end else if (wr_ctrl) begin
            ctrl_enable <= pwdata[RWB_CTRL_ENABLE_BIT];
        end
    end

endmodule

/* src/rwb_handshake.sv */
// control state machine for a one-deep read and one-deep write buffer
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module rwb_handshake
    import rwb_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // processor memory interface
    input  wire logic        cpu_phase_clock,
    input  wire logic        cpu_read_request_n,
    input  wire logic        cpu_write_request_n,
    input  wire logic        cpu_read_buffer_enable_n,
    output logic             read_stall,
    output logic             write_stall,
    // main memory handshake
    input  wire logic        memory_cycle_done_n,
    output logic             memory_request_pulse_n,
    output logic             memory_read_strobe_n,
    output logic             memory_write_strobe_n,
    // low address buffer controls
    output logic             addr_path_select,
    output logic             addr_register_clock,
    output logic             addr_register_enable_n,
    output logic             addr_port_a_drive_enable_n,
    output logic             addr_port_a_capture_enable_n,
    output logic             addr_port_b_drive_enable_n,
    output logic             addr_parity_sense,
    // data buffer controls
    output logic             data_path_select,
    output logic             data_register_clock,
    output logic             data_register_enable_n,
    output logic             data_port_a_drive_enable_n,
    output logic             data_port_a_capture_enable_n,
    output logic             data_port_b_drive_enable_n,
    output logic             data_parity_sense
);

    // ****************************************
    // internal state
    // ****************************************
    logic                 ctrl_enable;
    logic                 write_pending;
    logic                 delayed_write_request;
    logic                 request_issued;
    logic                 write_captured;
    logic                 mem_req;
    logic                 mem_rd;
    logic [RWB_CNT_W-1:0] read_count;
    logic [RWB_CNT_W-1:0] write_count;
    logic                 next_write_pending;
    logic                 next_read_stall;
    logic                 next_mem_req;
    logic                 next_mem_rd;
    logic                 next_issued;
    logic                 next_captured;

    // ****************************************
    // request decode
    // ****************************************
    // software can park the block; requests are then not seen at all
    wire rd_req   = ctrl_enable & ~cpu_read_request_n;
    wire wr_req   = ctrl_enable & ~cpu_write_request_n;
    wire cyc_done = ~memory_cycle_done_n;
    wire read_ack = cyc_done & ~write_pending & rd_req;
    wire write_ack = cyc_done & write_pending;

    // write accepted into the buffer: idle, no read, not yet taken
    wire write_capture = wr_req & ~write_pending & ~rd_req & ~write_captured;
    wire read_capture  = rd_req & ~write_pending & ~wr_req;

    // ****************************************
    // next-state equations
    // ****************************************
    // write pending rises on an idle write, falls on cycle done
    assign next_write_pending = write_capture |
                                (write_pending & ~cyc_done);

    // read stall idles high; cleared only by a read acknowledge
    assign next_read_stall = ~(read_ack | (~read_stall & rd_req));

    // one request per read or write; none while a write is pending.
    // a write capture is one-shot already, so only reads look at the
    // issued flag: a refill that just ended must not block its write
    assign next_mem_req = ~write_pending &
                          (write_capture | (rd_req & ~request_issued));

    // read strobe held as long as the read request stays up
    assign next_mem_rd = rd_req & (~write_pending | mem_rd);

    // issued flag stops repeat pulses during a block refill; it
    // follows the read request and clears on a write acknowledge, so a read held behind the write can go
    assign next_issued = (next_mem_req | request_issued) &
                         rd_req & ~write_ack;

    // captured flag keeps a held write request from retaking data;
    // the write acknowledge frees it for a stalled second write
    assign next_captured = wr_req & ~write_ack &
                           (write_captured | write_capture);

    // ****************************************
    // state registers
    // ****************************************
    // pclk stands for the inverted phase clock; power-up is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_pending  <= 1'b0;
            read_stall     <= 1'b1;
            mem_req        <= 1'b0;
            mem_rd         <= 1'b0;
            request_issued <= 1'b0;
            write_captured <= 1'b0;
        end else begin
            write_pending  <= next_write_pending;
            read_stall     <= next_read_stall;
            mem_req        <= next_mem_req;
            mem_rd         <= next_mem_rd;
            request_issued <= next_issued;
            write_captured <= next_captured;
        end
    end

    // one-cycle delayed copy of the write request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delayed_write_request <= 1'b0;
        end else begin
            delayed_write_request <= wr_req;
        end
    end

    // completed-transfer counters for software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_count  <= '0;
            write_count <= '0;
        end else begin
            if (read_ack && read_stall) begin
                read_count <= read_count + 1'b1;
            end
            if (write_ack) begin
                write_count <= write_count + 1'b1;
            end
        end
    end

    // ****************************************
    // memory handshake outputs
    // ****************************************
    // the write stall must be combinational so the processor sees it
    // in the same cycle as the read request
    assign write_stall            = write_pending | rd_req;
    assign memory_request_pulse_n = ~mem_req;
    assign memory_read_strobe_n   = ~mem_rd;
    assign memory_write_strobe_n  = ~write_pending;

    // ****************************************
    // low address buffer controls
    // ****************************************
    // low address bits are valid in the first phase, so the
    // non-inverted phase clock times their register
    assign addr_register_clock          = cpu_phase_clock;
    assign addr_path_select             = RWB_PATH_LATCH_REG;
    assign addr_register_enable_n       = ~(read_capture | write_capture);
    assign addr_port_a_drive_enable_n   = ~(write_pending | rd_req);
    assign addr_port_a_capture_enable_n = RWB_ENABLE_OFF_N;
    assign addr_port_b_drive_enable_n   = RWB_ENABLE_OFF_N;
    assign addr_parity_sense            = RWB_PARITY_PASS;

    // ****************************************
    // data buffer controls
    // ****************************************
    assign data_path_select             = RWB_PATH_LATCH_REG;
    assign data_register_clock          = ~cpu_phase_clock;
    assign data_register_enable_n       = ~write_capture;
    assign data_parity_sense            = RWB_PARITY_PASS;
    assign data_port_a_drive_enable_n   = ~write_pending;
    assign data_port_a_capture_enable_n = ~(rd_req & ~write_pending);
    // the processor owns read-buffer output timing
    assign data_port_b_drive_enable_n   = cpu_read_buffer_enable_n;

    // ****************************************
    // register file
    // ****************************************
    rwb_apb_regs u_regs (
        .pclk        (pclk),
        .presetn     (presetn),
        .paddr       (paddr),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .pwdata      (pwdata),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr),
        .ctrl_enable (ctrl_enable),
        .status_bits ({write_captured, delayed_write_request, mem_rd,
                       write_stall, read_stall, write_pending}),
        .read_count  (read_count),
        .write_count (write_count)
    );

    // ****************************************
    // assertions
    // ****************************************
    // the latency figures (two-cycle acknowledge, five-cycle read,
    // three-cycle write) rest on the memory side keeping its timing
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_WIP_SET: assert property (
        !write_pending && wr_req && !rd_req && !write_captured |=> write_pending)
        else $error("write pending not set on idle write");

    AST_WIP_HOLD: assert property (
        write_pending && !cyc_done |=> write_pending)
        else $error("write pending dropped before cycle done");

    AST_WIP_CLEAR: assert property (
        write_pending && cyc_done |=> !write_pending)
        else $error("write pending held after cycle done");

    AST_REQ_PULSE: assert property (
        mem_req |=> !mem_req)
        else $error("memory request longer than one cycle");

    AST_RD_STROBE: assert property (
        mem_rd && rd_req |=> mem_rd)
        else $error("read strobe dropped while read held");

    AST_RSTALL_STAY: assert property (
        !read_stall && rd_req |=> !read_stall)
        else $error("read stall reasserted during refill");

    AST_RSTALL_PRIOR: assert property (
        read_stall && write_pending && cyc_done |=> read_stall)
        else $error("write acknowledge released read stall");

    AST_RSTALL_REL: assert property (
        !write_pending && rd_req && cyc_done |=> !read_stall)
        else $error("read acknowledge did not release read stall");

    AST_NO_REQ_WIP: assert property (
        write_pending |=> !mem_req)
        else $error("memory request while write pending");

    AST_ABE_ONCE: assert property (
        write_capture |=> addr_register_enable_n && data_register_enable_n)
        else $error("write capture lasted more than one cycle");

    AST_WSTALL: assert property (
        rd_req && !write_pending |-> write_stall && data_port_a_drive_enable_n)
        else $error("write stall or drive wrong during read");

    AST_BOTH_STALL: assert property (
        write_pending ##1 write_pending |-> read_stall && write_stall)
        else $error("stall missing during write");

    COV_READ: cover property (
        mem_req && rd_req ##[1:4] (!read_stall && rd_req));
    COV_WRITE: cover property (
        write_capture ##1 write_pending [*2] ##1 !write_pending);
    COV_RD_AFTER_WR: cover property (
        write_pending && rd_req ##[1:4] (mem_req && rd_req));
    COV_WR_WR: cover property (
        write_pending && wr_req && write_captured ##[1:6] write_capture);
    COV_REFILL: cover property (
        !read_stall && cyc_done ##1 !read_stall && cyc_done);

    // previous read request, so a fresh read can be told apart
    // from one that is still being refilled
    logic rd_req_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_req_prev <= 1'b0;
        end else begin
            rd_req_prev <= rd_req;
        end
    end

    // a fresh read must reach memory at the next edge, or the
    // five-cycle read budget is lost before memory even starts
    AST_RD_FRESH: assert property (
        rd_req && !rd_req_prev && !write_pending |=> mem_req && mem_rd)
        else $error("fresh read not issued");

    AST_WR_REQ: assert property (
        write_capture |=> mem_req)
        else $error("captured write sent no request");

    AST_NO_ABE_WIP: assert property (
        write_pending |-> addr_register_enable_n)
        else $error("address register enabled during write");

    AST_NO_DBE_WIP: assert property (
        write_pending |-> data_register_enable_n)
        else $error("data register enabled during write");

    AST_STREAM_WR: assert property (
        wr_req && rd_req && !write_pending |=> !write_pending)
        else $error("write taken during streaming");

    AST_RD_STROBE_END: assert property (
        !rd_req |=> !mem_rd)
        else $error("read strobe held after read ended");

endmodule

/* src/rwb_pkg.sv */
// shared constants for the read/write buffer handshake control block
package rwb_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] RWB_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] RWB_STATUS_ADDR = 8'h04;
    localparam logic [7:0] RWB_RDCNT_ADDR  = 8'h08;
    localparam logic [7:0] RWB_WRCNT_ADDR  = 8'h0C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int RWB_CTRL_ENABLE_BIT  = 0;
    localparam int RWB_ST_WIP_BIT       = 0;
    localparam int RWB_ST_RSTALL_BIT    = 1;
    localparam int RWB_ST_WSTALL_BIT    = 2;
    localparam int RWB_ST_MRD_BIT       = 3;
    localparam int RWB_ST_DWR_BIT       = 4;
    localparam int RWB_ST_WCAP_BIT      = 5;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int          RWB_CNT_W         = 16;
    localparam int          RWB_ST_W          = 6;
    localparam logic        RWB_CTRL_ENABLE_RST = 1'b1;
    localparam logic [31:0] RWB_ZERO_WORD     = 32'h0000_0000;

    // ****************************************
    // fixed buffer strap levels
    // ****************************************
    localparam logic RWB_PATH_LATCH_REG  = 1'b1;  // latch then output register
    localparam logic RWB_PARITY_PASS     = 1'b0;  // even parity unchanged
    localparam logic RWB_ENABLE_OFF_N    = 1'b1;  // inactive active-low enable

    // ****************************************
    // apb access phases
    // ****************************************
    typedef enum logic [1:0] {
        RWB_APB_IDLE   = 2'b00,
        RWB_APB_SETUP  = 2'b01,
        RWB_APB_ACCESS = 2'b10
    } rwb_apb_phase_t;

endpackage

/* tb/rwb_mem_model.sv */
// memory controller model answering request pulses with cycle-done pulses
`timescale 1ns/1ps
module rwb_mem_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // handshake from the block
    input  wire logic       memory_request_pulse_n,
    input  wire logic       memory_read_strobe_n,
    // scenario controls
    input  wire logic [2:0] words,
    input  wire logic       slow,
    // acknowledge back to the block
    output logic            memory_cycle_done_n
);
    logic       armed;
    logic       armed_late;
    logic       fire;
    logic [2:0] left;

    // slow mode answers one cycle late to stretch the stall windows
    assign fire = slow ? armed_late : armed;

    // ****************************************
    // acknowledge sequencer
    // ****************************************
    // refill words keep coming only while the read strobe is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed               <= 1'b0;
            armed_late          <= 1'b0;
            left                <= 3'h0;
            memory_cycle_done_n <= 1'b1;
        end else begin
            armed               <= ~memory_request_pulse_n;
            armed_late          <= armed;
            memory_cycle_done_n <= 1'b1;
            if (fire) begin
                memory_cycle_done_n <= 1'b0;
                // a write acknowledge carries no refill words
                left                <= memory_read_strobe_n ? 3'h0 : 3'(words - 3'h1);
            end else if (left != 3'h0 && !memory_read_strobe_n) begin
                memory_cycle_done_n <= 1'b0;
                left                <= 3'(left - 3'h1);
            end
        end
    end
endmodule

/* tb/testbench.sv */
// self-checking bench for the read/write buffer handshake control
`timescale 1ns/1ps
module testbench
    import rwb_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, phs;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        rq_n, wq_n, xen_n, done_n, slow, rs, ws, memory_request_pulse, memory_read_strobe, memory_write_strobe;
    logic        a_sel, a_clk, abe, aao, aae, abo, apar;
    logic        d_sel, d_clk, dbe, dao, dae, dbo, dpar;
    logic [2:0]  words;
    int          miscompares, compares;

    // processor phase clock is the inverse of the block clock
    assign phs = ~pclk;

    rwb_handshake uut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
        .cpu_phase_clock(phs), .cpu_read_request_n(rq_n), .cpu_write_request_n(wq_n),
        .cpu_read_buffer_enable_n(xen_n), .read_stall(rs), .write_stall(ws),
        .memory_cycle_done_n(done_n), .memory_request_pulse_n(memory_request_pulse),
        .memory_read_strobe_n(memory_read_strobe), .memory_write_strobe_n(memory_write_strobe),
        .addr_path_select(a_sel), .addr_register_clock(a_clk), .addr_register_enable_n(abe),
        .addr_port_a_drive_enable_n(aao), .addr_port_a_capture_enable_n(aae),
        .addr_port_b_drive_enable_n(abo), .addr_parity_sense(apar),
        .data_path_select(d_sel), .data_register_clock(d_clk), .data_register_enable_n(dbe),
        .data_port_a_drive_enable_n(dao), .data_port_a_capture_enable_n(dae),
        .data_port_b_drive_enable_n(dbo), .data_parity_sense(dpar)
    );

    rwb_mem_model mem (
        .pclk, .presetn, .memory_request_pulse_n(memory_request_pulse), .memory_read_strobe_n(memory_read_strobe),
        .words, .slow, .memory_cycle_done_n(done_n)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic ck(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic ckw(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    // step n edges, then let the edge updates settle
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // one apb transfer; only the watchdog ends a wait for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        ck(pready, 1'b1, "apb no ready");
        rdata = prdata;
        perr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic test_done;
        $display("comparisons %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        $display("mismatch at %0t: timeout", $time);
        test_done();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, rq_n, wq_n, xen_n, slow} = 8'h0e;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        words = 3'h1;
        miscompares = 0;
        compares = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        ck(rs, 1'b1, "idle read stall");
        ck(memory_request_pulse & memory_read_strobe & memory_write_strobe & abe & aao & dbe & dao & dae, 1'b1, "idle");
        ck(ws, 1'b0, "idle write stall");
        ck(a_sel & d_sel & aae & abo, 1'b1, "straps");
        ck(apar | dpar, 1'b0, "parity sense");
        #4;
        ck(a_clk === phs && d_clk === pclk, 1'b1, "register clocks");
        apb(1'b0, RWB_CTRL_ADDR, 32'h0000_0000);
        ckw(rdata, {31'h0, RWB_CTRL_ENABLE_RST}, "ctrl reset");
        apb(1'b1, RWB_STATUS_ADDR, 32'hffff_ffff);
        apb(1'b0, RWB_STATUS_ADDR, 32'h0000_0000);
        ckw(rdata, 32'h1 << RWB_ST_RSTALL_BIT, "status idle");
        apb(1'b1, 8'h10, 32'h0000_0001);
        ck(perr, 1'b1, "unmapped write");
        apb(1'b0, 8'h10, 32'h0000_0000);
        ck(perr, 1'b1, "unmapped read");
        ckw(rdata, RWB_ZERO_WORD, "unmapped data");
        $display("test registers done");

        // single read, then the processor takes the word
        @(posedge pclk);
        rq_n <= 1'b0;
        #1;
        ck(ws, 1'b1, "write stall on read");
        ck(abe | aao | dae, 1'b0, "read enables");
        cyc(1);
        ck(memory_request_pulse | memory_read_strobe, 1'b0, "read request");
        cyc(1);
        ck(memory_request_pulse, 1'b1, "single pulse");
        cyc(1);
        ck(rs, 1'b1, "stall before done");
        cyc(1);
        ck(rs, 1'b0, "stall release");
        @(posedge pclk);
        xen_n <= 1'b0;
        #1;
        ck(dbo | memory_read_strobe, 1'b0, "read buffer out");
        @(posedge pclk);
        xen_n <= 1'b1;
        rq_n  <= 1'b1;
        cyc(1);
        ck(rs & memory_read_strobe, 1'b1, "read closed");
        cyc(3);
        $display("test read done");

        // single write
        @(posedge pclk);
        wq_n <= 1'b0;
        #1;
        ck(abe | dbe | ws | ~memory_write_strobe, 1'b0, "write capture");
        @(posedge pclk);
        wq_n <= 1'b1;
        #1;
        ck(memory_write_strobe | dao | memory_request_pulse | aao, 1'b0, "write start");
        ck(ws & rs & abe & dbe, 1'b1, "write stalls");
        cyc(2);
        ck(memory_write_strobe | done_n, 1'b0, "write held to done");
        cyc(1);
        ck(memory_write_strobe & dao & ~ws, 1'b1, "write retired");
        cyc(3);
        $display("test write done");

        // read requested behind a pending write
        @(posedge pclk);
        wq_n <= 1'b0;
        @(posedge pclk);
        wq_n <= 1'b1;
        rq_n <= 1'b0;
        cyc(1);
        ck(memory_request_pulse & memory_read_strobe & abe, 1'b1, "read held off");
        cyc(2);
        ck(rs & memory_read_strobe, 1'b1, "write done keeps stall");
        ck(abe, 1'b0, "read address capture");
        cyc(1);
        ck(memory_request_pulse | memory_read_strobe, 1'b0, "read after write");
        cyc(3);
        ck(rs, 1'b0, "read done");
        @(posedge pclk);
        rq_n <= 1'b1;
        cyc(3);
        $display("test read behind write done");

        // two writes back to back
        @(posedge pclk);
        wq_n <= 1'b0;
        cyc(1);
        ck(dbe & abe & ws, 1'b1, "second write held");
        cyc(2);
        ck(dbe & abe, 1'b1, "second write not captured");
        cyc(1);
        ck(dbe | abe, 1'b0, "second write capture");
        @(posedge pclk);
        wq_n <= 1'b1;
        #1;
        ck(memory_request_pulse | memory_write_strobe, 1'b0, "second request");
        cyc(6);
        $display("test back to back writes done");

        // slow four word refill with a write during streaming
        @(posedge pclk);
        rq_n  <= 1'b0;
        words <= 3'h4;
        slow  <= 1'b1;
        cyc(4);
        ck(rs & ~done_n, 1'b1, "slow first word");
        cyc(1);
        ck(rs, 1'b0, "refill release");
        @(posedge pclk);
        wq_n <= 1'b0;
        #1;
        ck(dbe & abe & ~rs, 1'b1, "write in stream");
        @(posedge pclk);
        rq_n <= 1'b1;
        #1;
        ck(rs | dbe | ~memory_write_strobe, 1'b0, "write in fixup");
        @(posedge pclk);
        wq_n <= 1'b1;
        #1;
        ck(memory_write_strobe | memory_request_pulse | ~rs, 1'b0, "write after stream");
        cyc(4);
        @(posedge pclk);
        slow  <= 1'b0;
        words <= 3'h1;
        cyc(3);
        $display("test refill done");

        // disabled block ignores the processor
        apb(1'b1, RWB_CTRL_ADDR, 32'h0000_0000);
        @(posedge pclk);
        rq_n <= 1'b0;
        cyc(2);
        ck(memory_request_pulse & memory_read_strobe & rs, 1'b1, "disabled");
        @(posedge pclk);
        rq_n <= 1'b1;
        apb(1'b1, RWB_CTRL_ADDR, 32'h0000_0001);
        apb(1'b0, RWB_RDCNT_ADDR, 32'h0000_0000);
        ckw(rdata, 32'h0000_0003, "read count");
        apb(1'b0, RWB_WRCNT_ADDR, 32'h0000_0000);
        ckw(rdata, 32'h0000_0005, "write count");
        $display("test control and counters done");
        test_done();
    end
endmodule
